// ### design/flash_programmer_erase_status.sv
// Programmer-mode erase, polling, status read and flash power states
// Behaviour
// - Erase always clears the whole array
// - Result pin reports erase success for checking
// - Polling flags held until next command write
// - Status read reports cause of abnormal end
// - Return code kept except non-status writes
// - Return code bits, reset zero, bits 3:2 unused
// - Top bit shows operation has finished
// - Second bit shows normal versus abnormal end
// - Low six bits zero; 00 run,10 bad,11 ok
// - Commands ignored during oscillator and setup time
// - After setup time enter memory read mode
// - Subactive: power-down unless disable bit set
// - Power-down state clears FLASH_READY
// - Subsleep, standby, watch put flash in standby
// - Wake wait of at least 20 us enforced
// - Erase is 20,20; status read is 71,71
// - After operation return to command wait
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module flash_programmer_erase_status import flash_seq_pkg::*; #(
	parameter int OSC_XTAL_CYCLES = OSC_XTAL_CYC,
	parameter int OSC_CER_CYCLES = OSC_CER_CYC,
	parameter int SETUP_CYCLES = SETUP_CYC,
	parameter int ERASE_CYCLES = ERASE_CYC
) (
	input wire logic CLOCK, // 125 MHz clock
	input wire logic RST_N, // Async reset, active low
	input wire logic CLK_EN, // Freezes all state when low
	input wire logic CE_N, // Programmer chip select
	input wire logic OE_N, // Programmer output enable
	input wire logic WE_N, // Programmer write strobe
	input wire logic [7:0] DATA_IN, // Data pins, input side
	output logic [7:0] DATA_OUT, // Data pins, output side
	output logic DATA_OE_N, // Low while driving data pins
	input wire logic OSC_IS_CERAMIC, // Strap: ceramic resonator
	input wire logic ARRAY_ERASE_FAIL, // Array verify failed
	output logic ARRAY_ERASE_BUSY, // Whole-array erase running
	input wire logic [2:0] LSI_MODE, // Chip operating mode
	output logic FLASH_POWERDOWN, // Flash in power-down
	output logic FLASH_STANDBY, // Flash in standby
	output logic FLASH_READY, // Flash in normal operation
	input wire logic [7:0] AWADDR, // AXI write address
	input wire logic AWVALID, // AXI
	output logic AWREADY, // AXI
	input wire logic [31:0] WDATA, // AXI write data
	input wire logic [3:0] WSTRB, // AXI byte strobes
	input wire logic WVALID, // AXI
	output logic WREADY, // AXI
	output logic [1:0] BRESP, // AXI
	output logic BVALID, // AXI
	input wire logic BREADY, // AXI
	input wire logic [7:0] ARADDR, // AXI read address
	input wire logic ARVALID, // AXI
	output logic ARREADY, // AXI
	output logic [31:0] RDATA, // AXI
	output logic [1:0] RRESP, // AXI
	output logic RVALID, // AXI
	input wire logic RREADY // AXI
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [11:0] pins_s;
	logic ce_n_s, oe_n_s, we_n_s, ceramic_s;
	logic [7:0] din_s;
	pin_sync #(.WIDTH(12), .RESET_VAL(12'hE00)) u_sync (
		.clk(CLOCK),
		.rst_n(RST_N),
		.en(CLK_EN),
		.d({CE_N, OE_N, WE_N, OSC_IS_CERAMIC, DATA_IN}),
		.q(pins_s)
	);
	assign {ce_n_s, oe_n_s, we_n_s, ceramic_s, din_s} = pins_s;

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	seq_state_t state_reg, state_next;
	out_sel_t out_reg, out_next;
	logic [1:0] poll_reg, poll_next;
	logic [7:0] code_reg, code_next;
	logic [31:0] cnt_reg, cnt_next;
	logic we_prev_reg, we_prev_next;
	logic [7:0] dout_reg, dout_next;
	logic doe_n_reg, doe_n_next;
	logic busy_reg, busy_next;
	logic cmd_wr;
	logic [31:0] lock_total;

	assign cmd_wr = we_n_s & ~we_prev_reg & ~ce_n_s;
	assign lock_total = (ceramic_s ? OSC_CER_CYCLES : OSC_XTAL_CYCLES)
		+ SETUP_CYCLES;

	always_comb begin
		state_next = state_reg;
		out_next = out_reg;
		poll_next = poll_reg;
		code_next = code_reg;
		cnt_next = cnt_reg;
		busy_next = busy_reg;
		we_prev_next = we_n_s;
		unique case (state_reg)
		S_LOCK: begin
			// Writes during settle and setup are dropped
			cnt_next = cnt_reg + 32'h1;
			if (cnt_reg >= lock_total - 32'h1) begin
				state_next = S_READ;
				cnt_next = 32'h0;
			end
		end
		S_ERASING: begin
			// Writes are ignored while the array erases
			cnt_next = cnt_reg + 32'h1;
			if (cnt_reg >= ERASE_CYCLES - 1) begin
				busy_next = 1'b0;
				state_next = S_WAIT;
				if (ARRAY_ERASE_FAIL) begin
					poll_next = POLL_ABNORMAL;
					code_next[CODE_ABNORMAL_BIT] = 1'b1;
					code_next[erase_fail_bit] = 1'b1;
				end else begin
					poll_next = POLL_NORMAL;
				end
			end
		end
		default: begin
			if (cmd_wr) begin
				// Any command write ends the held polling output
				out_next = OUT_NONE;
				if (!(state_reg == S_STAT2 ||
					(state_reg != S_ERASE2 && din_s == CMD_STATUS)))
					code_next = CODE_RESET;
				unique case (state_reg)
				S_ERASE2: begin
					if (din_s == CMD_ERASE) begin
						state_next = S_ERASING;
						poll_next = POLL_RUNNING;
						out_next = OUT_POLL;
						busy_next = 1'b1;
						cnt_next = 32'h0;
					end
				end
				S_STAT2: begin
					if (din_s == CMD_STATUS) begin
						state_next = S_WAIT;
						out_next = OUT_STATUS;
					end
				end
				default: begin
					if (din_s == CMD_ERASE)
						state_next = S_ERASE2;
					else if (din_s == CMD_STATUS)
						state_next = S_STAT2;
					else if (din_s == CMD_MEM_READ)
						state_next = S_READ;
				end
				endcase
				if ((state_reg == S_ERASE2 && din_s != CMD_ERASE) ||
					(state_reg == S_STAT2 && din_s != CMD_STATUS) ||
					(state_reg != S_ERASE2 && state_reg != S_STAT2 &&
					din_s != CMD_ERASE && din_s != CMD_STATUS &&
					din_s != CMD_MEM_READ)) begin
					state_next = S_WAIT;
					poll_next = POLL_ABNORMAL;
					out_next = OUT_POLL;
					code_next = CODE_RESET;
					code_next[CODE_ABNORMAL_BIT] = 1'b1;
					code_next[CODE_CMD_ERR_BIT] = 1'b1;
				end
			end
		end
		endcase
		// Pins driven only while chip select and output enable are low
		doe_n_next = ~(~ce_n_s & ~oe_n_s & (out_next != OUT_NONE));
		if (out_next == OUT_STATUS)
			dout_next = code_next;
		else if (out_next == OUT_POLL)
			dout_next = {poll_next, 6'h00};
		else
			dout_next = 8'h00;
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= S_LOCK;
			out_reg <= OUT_NONE;
			poll_reg <= POLL_RUNNING;
			code_reg <= CODE_RESET;
			cnt_reg <= 32'h0;
			we_prev_reg <= 1'b1;
			dout_reg <= 8'h00;
			doe_n_reg <= 1'b1;
			busy_reg <= 1'b0;
		end else if (CLK_EN) begin
			state_reg <= state_next;
			out_reg <= out_next;
			poll_reg <= poll_next;
			code_reg <= code_next;
			cnt_reg <= cnt_next;
			we_prev_reg <= we_prev_next;
			dout_reg <= dout_next;
			doe_n_reg <= doe_n_next;
			busy_reg <= busy_next;
		end
	end
	assign DATA_OUT = dout_reg;
	assign DATA_OE_N = doe_n_reg;
	assign ARRAY_ERASE_BUSY = busy_reg;

	// ------------------------------------------------------------
	// Flash power state
	// ------------------------------------------------------------
	fl_state_t fl_reg, fl_next;
	logic [14:0] wake_reg, wake_next;
	logic pd_reg, pd_next, sb_reg, sb_next, rdy_reg, rdy_next;
	logic flash_powerdown_disable_reg, flash_powerdown_disable_next;
	logic [2:0] wsel_reg, wsel_next;
	fl_state_t target;

	always_comb begin
		if (LSI_MODE == MODE_ACTIVE || LSI_MODE == MODE_SLEEP)
			target = FL_NORMAL;
		else if (LSI_MODE == MODE_SUBACTIVE)
			target = flash_powerdown_disable_reg ? FL_NORMAL : FL_PDOWN;
		else
			target = FL_STBY;
		fl_next = fl_reg;
		wake_next = wake_reg;
		if (target != FL_NORMAL) begin
			fl_next = target;
		end else if (fl_reg == FL_PDOWN || fl_reg == FL_STBY) begin
			fl_next = FL_WAKING;
			// Never below the minimum, whatever the select holds
			wake_next = 15'(WAKE_MIN_CYC * (int'(wsel_reg) + 1));
		end else if (fl_reg == FL_WAKING) begin
			wake_next = wake_reg - 15'h1;
			if (wake_reg <= 15'h1)
				fl_next = FL_NORMAL;
		end
		pd_next = (fl_next == FL_PDOWN);
		sb_next = (fl_next == FL_STBY);
		rdy_next = (fl_next == FL_NORMAL);
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			fl_reg <= FL_NORMAL;
			wake_reg <= 15'h0;
			pd_reg <= 1'b0;
			sb_reg <= 1'b0;
			rdy_reg <= 1'b1;
		end else if (CLK_EN) begin
			fl_reg <= fl_next;
			wake_reg <= wake_next;
			pd_reg <= pd_next;
			sb_reg <= sb_next;
			rdy_reg <= rdy_next;
		end
	end
	assign FLASH_POWERDOWN = pd_reg;
	assign FLASH_STANDBY = sb_reg;
	assign FLASH_READY = rdy_reg;

	// ------------------------------------------------------------
	// AXI4-Lite register slave
	// ------------------------------------------------------------
	logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
	logic [7:0] awa_reg, awa_next;
	logic [31:0] wd_reg, wd_next;
	logic wst_reg, wst_next;
	logic bv_reg, bv_next, rv_reg, rv_next;
	logic [1:0] br_reg, br_next, rr_reg, rr_next;
	logic [31:0] rd_reg, rd_next;

	always_comb begin
		aw_got_next = aw_got_reg;
		w_got_next = w_got_reg;
		awa_next = awa_reg;
		wd_next = wd_reg;
		wst_next = wst_reg;
		bv_next = bv_reg;
		br_next = br_reg;
		rv_next = rv_reg;
		rr_next = rr_reg;
		rd_next = rd_reg;
		flash_powerdown_disable_next = flash_powerdown_disable_reg;
		wsel_next = wsel_reg;
		if (AWVALID && !aw_got_reg) begin
			aw_got_next = 1'b1;
			awa_next = AWADDR;
		end
		if (WVALID && !w_got_reg) begin
			w_got_next = 1'b1;
			wd_next = WDATA;
			wst_next = WSTRB[0];
		end
		if (aw_got_reg && w_got_reg && !bv_reg) begin
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			bv_next = 1'b1;
			br_next = RESP_OKAY;
			if (awa_reg == ADDR_FLASH_POWER_CONTROL) begin
				if (wst_reg)
					flash_powerdown_disable_next = wd_reg[0];
			end else if (awa_reg == ADDR_SYSTEM_CONTROL_ONE) begin
				if (wst_reg)
					wsel_next = wd_reg[2:0];
			end else begin
				br_next = RESP_SLVERR;
			end
		end else if (bv_reg && BREADY) begin
			bv_next = 1'b0;
		end
		if (ARVALID && !rv_reg) begin
			rv_next = 1'b1;
			rr_next = RESP_OKAY;
			if (ARADDR == ADDR_FLASH_POWER_CONTROL)
				rd_next = {31'h0, flash_powerdown_disable_reg};
			else if (ARADDR == ADDR_SYSTEM_CONTROL_ONE)
				rd_next = {29'h0, wsel_reg};
			else if (ARADDR == ADDR_SEQ_STATUS)
				rd_next = {16'h0, code_reg, 2'h0, poll_reg, busy_reg,
					pd_reg, sb_reg, rdy_reg};
			else begin
				rd_next = 32'h0;
				rr_next = RESP_SLVERR;
			end
		end else if (rv_reg && RREADY) begin
			rv_next = 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awa_reg <= 8'h00;
			wd_reg <= 32'h0;
			wst_reg <= 1'b0;
			bv_reg <= 1'b0;
			br_reg <= RESP_OKAY;
			rv_reg <= 1'b0;
			rr_reg <= RESP_OKAY;
			rd_reg <= 32'h0;
			flash_powerdown_disable_reg <= flash_powerdown_disable_RESET;
			wsel_reg <= WAIT_SELECT_RESET;
		end else if (CLK_EN) begin
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			awa_reg <= awa_next;
			wd_reg <= wd_next;
			wst_reg <= wst_next;
			bv_reg <= bv_next;
			br_reg <= br_next;
			rv_reg <= rv_next;
			rr_reg <= rr_next;
			rd_reg <= rd_next;
			flash_powerdown_disable_reg <= flash_powerdown_disable_next;
			wsel_reg <= wsel_next;
		end
	end
	assign AWREADY = ~aw_got_reg;
	assign WREADY = ~w_got_reg;
	assign BVALID = bv_reg;
	assign BRESP = br_reg;
	assign ARREADY = ~rv_reg;
	assign RVALID = rv_reg;
	assign RRESP = rr_reg;
	assign RDATA = rd_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	logic [14:0] wake_age_reg;
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			wake_age_reg <= 15'h0;
		else if (CLK_EN)
			wake_age_reg <= (fl_reg == FL_WAKING) ?
				wake_age_reg + 15'h1 : 15'h0;
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	sequence s_erase_second;
		CLK_EN && cmd_wr && state_reg == S_ERASE2 && din_s == CMD_ERASE;
	endsequence
	sequence s_erasing;
		state_reg == S_ERASING && poll_reg == POLL_RUNNING && busy_reg;
	endsequence
	property p_erase_start;
		s_erase_second |=> s_erasing;
	endproperty
	a_erase_start: assert property (p_erase_start)
		else $error("second erase byte did not start erase");
	property p_poll_low;
		!DATA_OE_N && out_reg == OUT_POLL |-> DATA_OUT[5:0] == 6'h00;
	endproperty
	a_poll_low: assert property (p_poll_low)
		else $error("polling low bits not zero");
	property p_no_01;
		poll_reg != 2'h1;
	endproperty
	a_no_01: assert property (p_no_01)
		else $error("undefined polling pair");
	property p_hold;
		CLK_EN && !cmd_wr && state_reg != S_ERASING |=> $stable(poll_reg);
	endproperty
	a_hold: assert property (p_hold)
		else $error("polling flags changed without write");
	property p_drive;
		CLK_EN && !ce_n_s && !oe_n_s && out_reg != OUT_NONE && !cmd_wr
			|=> !DATA_OE_N;
	endproperty
	a_drive: assert property (p_drive)
		else $error("flags not driven on read");
	property p_code_keep;
		CLK_EN && cmd_wr && state_reg == S_STAT2 && din_s == CMD_STATUS
			|=> $stable(code_reg);
	endproperty
	a_code_keep: assert property (p_code_keep)
		else $error("status write altered return code");
	property p_lock;
		CLK_EN && state_reg == S_LOCK && cnt_reg < lock_total - 32'h1
			|=> state_reg == S_LOCK;
	endproperty
	a_lock: assert property (p_lock)
		else $error("left lockout early");
	property p_lock_exit;
		CLK_EN && state_reg == S_LOCK && cnt_reg == lock_total - 32'h1
			|=> state_reg == S_READ;
	endproperty
	a_lock_exit: assert property (p_lock_exit)
		else $error("no memory read mode after setup");
	property p_pdown;
		CLK_EN && LSI_MODE == MODE_SUBACTIVE && !flash_powerdown_disable_reg
			|=> FLASH_POWERDOWN && !FLASH_READY;
	endproperty
	a_pdown: assert property (p_pdown)
		else $error("subactive did not power down flash");
	property p_stby;
		CLK_EN && (LSI_MODE == MODE_SUBSLEEP || LSI_MODE == MODE_STANDBY ||
			LSI_MODE == MODE_WATCH) |=> FLASH_STANDBY;
	endproperty
	a_stby: assert property (p_stby)
		else $error("flash not in standby");
	property p_wake;
		CLK_EN && fl_reg == FL_WAKING && fl_next == FL_NORMAL
			|-> wake_age_reg >= 15'(WAKE_MIN_CYC - 1);
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake wait shorter than minimum");
endmodule

// ### design/flash_seq_pkg.sv
// Constants for the programmer-mode flash sequencer
package flash_seq_pkg;
	// ------------------------------------------------------------
	// Command bytes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_MEM_READ = 8'h00;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_STATUS = 8'h71;
	// ------------------------------------------------------------
	// Return code bit positions
	// ------------------------------------------------------------
	localparam int CODE_ABNORMAL_BIT = 7;
	localparam int CODE_CMD_ERR_BIT = 6;
	localparam int program_fail_bit = 5;
	localparam int erase_fail_bit = 4;
	localparam int cycle_overcount_bit = 1;
	localparam int bad_address_bit = 0;
	localparam logic [7:0] CODE_RESET = 8'h00;
	// Polling pair {busy_done, result}
	localparam logic [1:0] POLL_RUNNING = 2'h0;
	localparam logic [1:0] POLL_ABNORMAL = 2'h2;
	localparam logic [1:0] POLL_NORMAL = 2'h3;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int OSC_XTAL_MS = 10;
	localparam int OSC_CER_MS = 5;
	localparam int SETUP_MS = 10;
	localparam int ERASE_MIN_MS = 100;
	localparam int WAKE_MIN_US = 20;
	localparam int OSC_XTAL_CYC = OSC_XTAL_MS * 1000 * CLK_MHZ;
	localparam int OSC_CER_CYC = OSC_CER_MS * 1000 * CLK_MHZ;
	localparam int SETUP_CYC = SETUP_MS * 1000 * CLK_MHZ;
	localparam int ERASE_CYC = ERASE_MIN_MS * 1000 * CLK_MHZ;
	localparam int WAKE_MIN_CYC = WAKE_MIN_US * CLK_MHZ;
	// ------------------------------------------------------------
	// Chip operating modes
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_ACTIVE = 3'h0;
	localparam logic [2:0] MODE_SUBACTIVE = 3'h1;
	localparam logic [2:0] MODE_SLEEP = 3'h2;
	localparam logic [2:0] MODE_SUBSLEEP = 3'h3;
	localparam logic [2:0] MODE_STANDBY = 3'h4;
	localparam logic [2:0] MODE_WATCH = 3'h5;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_FLASH_POWER_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_SYSTEM_CONTROL_ONE = 8'h04;
	localparam logic [7:0] ADDR_SEQ_STATUS = 8'h08;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic flash_powerdown_disable_RESET = 1'b0;
	localparam logic [2:0] WAIT_SELECT_RESET = 3'h0;

	typedef enum {S_LOCK, S_READ, S_WAIT, S_ERASE2, S_STAT2, S_ERASING}
		seq_state_t;
	typedef enum {OUT_NONE, OUT_POLL, OUT_STATUS} out_sel_t;
	typedef enum {FL_NORMAL, FL_PDOWN, FL_STBY, FL_WAKING} fl_state_t;
endpackage

// ### design/pin_sync.sv
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Async reset
	input wire logic en, // Clock enable
	input wire logic [WIDTH-1:0] d, // Raw pins
	output logic [WIDTH-1:0] q // Synchronised
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_reg <= RESET_VAL[i];
					s2_reg <= RESET_VAL[i];
				end else if (en) begin
					s1_reg <= d[i];
					s2_reg <= s1_reg;
				end
			end
			assign q[i] = s2_reg;
		end
	endgenerate
endmodule

// ### verification/flash_prog_model.sv
// Programmer model driving the flash command pins
`timescale 1ns/1ps
module flash_prog_model import flash_seq_pkg::*; #(
	parameter int NXTC_CYC = 2500,
	parameter int POLL_WAIT_CYC = 60
) (
	input wire logic clk, // Clock
	output logic ce_n, // Chip select
	output logic oe_n, // Output enable
	output logic we_n, // Write strobe
	output logic drive, // Drives the data wire
	output logic [7:0] dout, // Value driven
	output logic seen // Read sampled at next edge
);
	initial begin
		ce_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
		drive = 1'b0;
		dout = 8'hFF;
		seen = 1'b0;
	end
	// ------------------------------------------------------------
	// Pin cycles
	// ------------------------------------------------------------
	task automatic write_cmd(input logic [7:0] b, input int gap);
		@(posedge clk);
		ce_n <= 1'b0;
		drive <= 1'b1;
		dout <= b;
		repeat (4) @(posedge clk);
		we_n <= 1'b0;
		repeat (4) @(posedge clk);
		we_n <= 1'b1;
		repeat (5) @(posedge clk);
		ce_n <= 1'b1;
		drive <= 1'b0;
		dout <= ~b;
		repeat (gap) @(posedge clk);
	endtask
	task automatic read_pins();
		@(posedge clk);
		ce_n <= 1'b0;
		oe_n <= 1'b0;
		repeat (6) @(posedge clk);
		seen <= 1'b1;
		@(posedge clk);
		seen <= 1'b0;
		ce_n <= 1'b1;
		oe_n <= 1'b1;
		repeat (5) @(posedge clk);
	endtask
	task automatic erase();
		write_cmd(CMD_ERASE, 0);
		write_cmd(CMD_ERASE, 2);
	endtask
	task automatic status_read();
		write_cmd(CMD_STATUS, 0);
		write_cmd(CMD_STATUS, NXTC_CYC);
		read_pins();
	endtask
	task automatic await_poll();
		repeat (POLL_WAIT_CYC) @(posedge clk);
		read_pins();
	endtask
endmodule

// ### verification/test_flash_programmer_erase_status.sv
// Self-checking bench for the programmer-mode flash sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	n_fail++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_flash_programmer_erase_status import flash_seq_pkg::*;;
	typedef struct {logic [33:0] val; logic [33:0] mask;} axi_exp_t;
	logic CLOCK = 1'b0, RST_N = 1'b0, ARRAY_ERASE_FAIL = 1'b0;
	logic CLK_EN = 1'b1, OSC_IS_CERAMIC = 1'b0;
	logic [3:0] WSTRB = 4'hF;
	logic [2:0] LSI_MODE = MODE_ACTIVE;
	logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, float_pat = 8'h3C, bus;
	logic [31:0] WDATA = 32'h0;
	logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, BUSY, PD, SB, RDY;
	logic [1:0] BRESP, RRESP;
	logic [31:0] RDATA, d;
	logic [7:0] DATA_OUT, bad;
	logic DATA_OE_N, ce_n, oe_n, we_n, drive, seen;
	logic [7:0] dout;
	logic [9:0] pin_q[$];
	axi_exp_t axi_q[$];
	int n_fail = 0, num_checks = 0;
	always #4 CLOCK = ~CLOCK;
	always @(posedge CLOCK) float_pat <= float_pat + 8'h5B;
	assign bus = !DATA_OE_N ? DATA_OUT : drive ? dout : float_pat;
	flash_programmer_erase_status #(.OSC_XTAL_CYCLES(20),
		.OSC_CER_CYCLES(10), .SETUP_CYCLES(20), .ERASE_CYCLES(50))
	u_flash_programmer_erase_status (.CLOCK(CLOCK), .RST_N(RST_N),
		.CLK_EN(CLK_EN), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n),
		.DATA_IN(bus), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
		.OSC_IS_CERAMIC(OSC_IS_CERAMIC),
		.ARRAY_ERASE_FAIL(ARRAY_ERASE_FAIL),
		.ARRAY_ERASE_BUSY(BUSY), .LSI_MODE(LSI_MODE),
		.FLASH_POWERDOWN(PD), .FLASH_STANDBY(SB), .FLASH_READY(RDY),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
	flash_prog_model u_prog (
		.clk(CLOCK), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.drive(drive), .dout(dout), .seen(seen));
	// ------------------------------------------------------------
	// Result monitor
	// ------------------------------------------------------------
	always @(posedge CLOCK) begin
		if (seen) begin
			if (pin_q.size() == 0) `CHK("pin queue", 1'b1, 1'b0)
			else `CHK("pins", pin_q.pop_front(), {BUSY,DATA_OE_N,bus})
		end
		if ((RVALID && RREADY) || (BVALID && BREADY)) begin
			if (axi_q.size() == 0) `CHK("axi queue", 1'b1, 1'b0)
			else begin
				axi_exp_t a;
				a = axi_q.pop_front();
				`CHK("axi", a.val, a.mask & (RVALID ?
					{RRESP, RDATA} : {BRESP, 32'h0}))
				// Power-state reads also check the state pins
				if (RVALID && a.mask == {2'h3, 32'h7})
					`CHK("flash state", a.val[2:0], {PD, SB, RDY})
			end
		end
	end
	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		axi_q.push_back('{{RESP_OKAY, 32'h0}, {2'h3, 32'h0}});
		@(posedge CLOCK);
		AWADDR <= a;
		WDATA <= v;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do begin
			@(posedge CLOCK);
			if (AWVALID && AWREADY) AWVALID <= 1'b0;
			if (WVALID && WREADY) WVALID <= 1'b0;
		end while (!BVALID);
		BREADY <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [33:0] e,
		input logic [31:0] m);
		axi_q.push_back('{e, {2'h3, m}});
		@(posedge CLOCK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do begin
			@(posedge CLOCK);
			if (ARVALID && ARREADY) ARVALID <= 1'b0;
		end while (!RVALID);
		RREADY <= 1'b0;
	endtask
	task automatic pins(input logic [7:0] e, input logic b = 1'b0);
		pin_q.push_back({b, 1'b0, e});
	endtask
	task automatic done(input string nm);
		$display("test %s finished", nm);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#800000;
		n_fail++;
		print_verdict();
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		d = $urandom(32'h5142);
		bad = 8'h55 ^ 8'($urandom() & 32'h0E);
		repeat (20) @(posedge CLOCK);
		RST_N <= 1'b1;
		u_prog.write_cmd(bad, 0);
		axi_rd(ADDR_FLASH_POWER_CONTROL, 34'h0, 32'h1);
		axi_rd(ADDR_SYSTEM_CONTROL_ONE, 34'h0, 32'hF);
		axi_rd(ADDR_SEQ_STATUS, 34'h1, 32'hFF0F);
		axi_rd(8'h0C, {RESP_SLVERR, 32'h0}, 32'hFFFFFFFF);
		repeat (60) @(posedge CLOCK);
		axi_rd(ADDR_SEQ_STATUS, 34'h1, 32'hFF0F);
		done("reset and lockout");
		u_prog.write_cmd(bad, 20);
		pins(8'h80);
		u_prog.read_pins();
		pins(8'hC0);
		u_prog.status_read();
		pins(8'hC0);
		u_prog.status_read();
		done("command error");
		for (int f = 0; f < 2; f++) begin
			ARRAY_ERASE_FAIL <= f[0];
			u_prog.erase();
			axi_rd(ADDR_SEQ_STATUS, 34'h8, 32'h38);
			pins(8'h00, 1'b1);
			u_prog.read_pins();
			pins(f ? 8'h80 : 8'hC0);
			u_prog.await_poll();
			axi_rd(ADDR_SEQ_STATUS, f ? 34'h20 : 34'h30, 32'h38);
			pins(f ? 8'h90 : 8'h00);
			u_prog.status_read();
			done("erase");
		end
		axi_wr(ADDR_SYSTEM_CONTROL_ONE, 32'h0);
		for (int p = 0; p < 2; p++) begin
			d = $urandom();
			d[0] = p[0];
			axi_wr(ADDR_FLASH_POWER_CONTROL, d);
			axi_rd(ADDR_FLASH_POWER_CONTROL, {33'h0, p[0]}, 32'h1);
			for (int m = 0; m < 6; m++) begin
				logic [33:0] e;
				e = (m == 1 && p == 0) ? 34'h4 : (m >= 3) ? 34'h2 : 34'h1;
				LSI_MODE <= m[2:0];
				repeat (4) @(posedge CLOCK);
				axi_rd(ADDR_SEQ_STATUS, e, 32'h7);
				LSI_MODE <= MODE_ACTIVE;
				repeat (2400) @(posedge CLOCK);
				axi_rd(ADDR_SEQ_STATUS, e == 1, 32'h7);
				repeat (200) @(posedge CLOCK);
				axi_rd(ADDR_SEQ_STATUS, 34'h1, 32'h7);
			end
			done("power states");
		end
		// Byte strobe off leaves the register alone
		WSTRB <= 4'hE;
		axi_wr(ADDR_FLASH_POWER_CONTROL, 32'h0);
		axi_rd(ADDR_FLASH_POWER_CONTROL, 34'h1, 32'h1);
		WSTRB <= 4'hF;
		// Clock enable low freezes the erase count
		u_prog.erase();
		CLK_EN <= 1'b0;
		repeat (100) @(posedge CLOCK);
		CLK_EN <= 1'b1;
		axi_rd(ADDR_SEQ_STATUS, 34'h8, 32'h38);
		// Mid-run reset with the ceramic strap: shorter lockout
		OSC_IS_CERAMIC <= 1'b1;
		RST_N <= 1'b0;
		repeat (2) @(posedge CLOCK);
		RST_N <= 1'b1;
		axi_rd(ADDR_FLASH_POWER_CONTROL, 34'h0, 32'h1);
		repeat (20) @(posedge CLOCK);
		u_prog.write_cmd(bad, 0);
		pins(8'h80);
		u_prog.read_pins();
		done("strobe, enable and strap");
		print_verdict();
	end
endmodule
